/* src/ucc_consts.svh */
// offsets, reset values, field positions and timing for the config registers
`ifndef UCC_CONSTS_SVH
`define UCC_CONSTS_SVH
`define UCC_OFS_GEN 8'h15
`define UCC_OFS_EMU 8'h16
`define UCC_RST_GEN 8'h01
`define UCC_RST_EMU 8'h8c
`define UCC_KEEP_GEN 8'hbb
`define UCC_KEEP_EMU 8'h9f
`define UCC_BIT_CLEAR 2
`define UCC_CLK_KHZ 125000
`define UCC_WAIT0_MS 50
`define UCC_WAIT1_MS 75
`define UCC_WAIT2_MS 125
`define UCC_WAIT3_MS 175
`define UCC_DISCH_MS 100
`define UCC_DWELL_MS 1000
`define UCC_NPROF 10
`define UCC_CHARGE_W 16
`endif

/* src/ucc_pkg.sv */
// types shared by the charger port configuration block
`include "ucc_consts.svh"
package ucc_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ucc_reg_req_type;
   typedef struct packed {
      logic alert_mask;
      logic unused6;
      logic alert_link;
      logic forced_bus_discharge;
      logic quota_enable;
      logic quota_clear;
      logic [1:0] quota_action_select;
   } ucc_gen_cfg_type;
   typedef struct packed {
      logic bus_timeout_off;
      logic [1:0] unused65;
      logic profile_timeout_off;
      logic cycle_repeat;
      logic hold_last_response;
      logic [1:0] emulation_reset_wait_select;
   } ucc_emu_cfg_type;
   typedef struct packed {
      logic error_pending;
      logic indicator_pending;
      logic low_current_flag;
      logic thermal_regulation_flag;
   } ucc_event_type;
   typedef struct packed {
      logic valid;
      logic [`UCC_CHARGE_W-1:0] value;
   } ucc_sample_type;
   typedef struct packed {
      logic [3:0] profile_index;
      logic apply;
      logic accepted;
      logic lines_hiz;
      logic switch_closed;
      logic custom_limit_mode;
      logic reset_active;
   } ucc_emu_out_type;
   typedef enum logic [1:0] {
      QA_REPORT = 2'b00,
      QA_REPORT_DISC = 2'b01,
      QA_DISC_SLEEP = 2'b10,
      QA_IGNORE = 2'b11
   } ucc_action_type;
   typedef enum logic [1:0] {
      PS_SLEEP = 2'b00,
      PS_DETECT = 2'b01,
      PS_ACTIVE = 2'b10,
      PS_ERROR = 2'b11
   } ucc_pwr_type;
   typedef enum logic [2:0] {
      EM_IDLE = 3'b000,
      EM_APPLY = 3'b001,
      EM_CHARGE = 3'b010,
      EM_RESET = 3'b011,
      EM_DONE = 3'b100
   } ucc_emu_mode_type;
endpackage : ucc_pkg

/* src/ucc_emu_cycle.sv */
// dedicated charger emulation cycle sequencer
`timescale 1ns/1ns
`include "ucc_consts.svh"
module ucc_emu_cycle #(
   parameter int NPROF = `UCC_NPROF,
   parameter int CYC_PER_MS = `UCC_CLK_KHZ,
   parameter int DWELL_MS = `UCC_DWELL_MS,
   parameter int DISCH_MS = `UCC_DISCH_MS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // control
   input wire ucc_pkg::ucc_emu_cfg_type cfg,
   input wire logic dedicated_charger_cycle,
   input wire logic cycle_start,
   input wire logic [NPROF-1:0] profile_enable,
   input wire logic custom_timeout_en,
   input wire logic over_charging_threshold,
   input wire logic removal_event,
   // status
   output ucc_pkg::ucc_emu_out_type status
);
   import ucc_pkg::*;
   localparam int DWELL_CYC = DWELL_MS * CYC_PER_MS;
   localparam logic [3:0] CUSTOM = 4'(NPROF - 1);
   typedef struct packed {
      ucc_emu_mode_type mode;
      logic hold;
      logic [31:0] timer;
      ucc_emu_out_type out;
   } ucc_emu_state_type;
   ucc_emu_state_type s, n;
   logic to_on;
   logic [4:0] f_first, f_next;

   // lowest enabled profile at or above from; bit 4 marks found
   function automatic logic [4:0] find_from(input logic [NPROF-1:0] m, input logic [4:0] from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NPROF - 1; i >= 0; i--)
         if (m[i] && 5'(i) >= from)
            r = {1'b1, 4'(i)};
      return r;
   endfunction : find_from

   // selected wait plus discharge
   // reset wait plus discharge, minus one for the down count
   function automatic logic [31:0] wait_cyc(input logic [1:0] sel);
      int ms;
      unique case (sel)
         2'b00: ms = `UCC_WAIT0_MS;
         2'b01: ms = `UCC_WAIT1_MS;
         2'b10: ms = `UCC_WAIT2_MS;
         2'b11: ms = `UCC_WAIT3_MS;
      endcase
      return 32'((ms + DISCH_MS) * CYC_PER_MS - 1);
   endfunction : wait_cyc

   always_comb
   begin
      n = s;
      f_first = find_from(profile_enable, 5'h00);
      f_next = find_from(profile_enable, {1'b0, s.out.profile_index} + 5'h01);
      to_on = !cfg.profile_timeout_off && (s.out.profile_index != CUSTOM || custom_timeout_en);
      unique case (s.mode)
         EM_IDLE:
            if (cycle_start && f_first[4])
            begin
               n.mode = EM_APPLY;
               n.out.profile_index = f_first[3:0];
               n.timer = 32'(DWELL_CYC - 1);
            end
         EM_APPLY:
            if (!to_on && over_charging_threshold)
            begin
               n.mode = EM_CHARGE;
               n.hold = 1'b1;
            end
            else if (to_on && s.timer == 32'h0)
            begin
               if (over_charging_threshold)
               begin
                  n.mode = EM_CHARGE;
                  n.hold = cfg.hold_last_response;
               end
               else if (f_next[4])
               begin
                  n.out.profile_index = f_next[3:0];
                  n.timer = 32'(DWELL_CYC - 1);
               end
               else if (cfg.cycle_repeat)
               begin
                  n.mode = EM_RESET;
                  n.timer = wait_cyc(cfg.emulation_reset_wait_select);
               end
               else
                  n.mode = EM_DONE;
            end
            else if (to_on)
               n.timer = s.timer - 32'h1;
         EM_RESET:
            if (s.timer != 32'h0)
               n.timer = s.timer - 32'h1;
            else if (f_first[4])
            begin
               n.mode = EM_APPLY;
               n.out.profile_index = f_first[3:0];
               n.timer = 32'(DWELL_CYC - 1);
            end
            else
               n.mode = EM_IDLE;
         EM_CHARGE, EM_DONE:
            if (removal_event || cycle_start)
               n.mode = EM_IDLE;
         default:
            n.mode = EM_IDLE;
      endcase
      if (!dedicated_charger_cycle)
         n.mode = EM_IDLE;
      if (n.mode != EM_CHARGE)
         n.hold = 1'b0;
      n.out.accepted = n.mode == EM_CHARGE;
      n.out.apply = n.mode == EM_APPLY || (n.mode == EM_CHARGE && n.hold);
      n.out.lines_hiz = n.mode == EM_DONE;
      n.out.switch_closed = n.mode == EM_DONE || n.mode == EM_CHARGE;
      n.out.custom_limit_mode = n.mode == EM_DONE;
      n.out.reset_active = n.mode == EM_RESET;
   end

   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
         s <= '0;
      else
         s <= n;

   assign status = s.out;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_not_dedicated;
      !dedicated_charger_cycle |=> !status.apply && !status.reset_active && !status.lines_hiz;
   endproperty
   a_not_dedicated: assert property (p_not_dedicated) else $error("emulation active outside mode");
endmodule : ucc_emu_cycle

/* src/ucc_config_regs.sv */
// general and emulation configuration registers with their controlled logic
`timescale 1ns/1ns
`include "ucc_consts.svh"
module ucc_config_regs #(
   parameter int NPROF = `UCC_NPROF,
   parameter int CYC_PER_MS = `UCC_CLK_KHZ,
   parameter int DWELL_MS = `UCC_DWELL_MS,
   parameter int DISCH_MS = `UCC_DISCH_MS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register port from the serial target
   input wire ucc_pkg::ucc_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   // device status
   input wire ucc_pkg::ucc_event_type events,
   input wire ucc_pkg::ucc_pwr_type power_state,
   input wire ucc_pkg::ucc_sample_type current_sample,
   input wire logic [`UCC_CHARGE_W-1:0] quota_threshold,
   // emulation inputs
   input wire logic dedicated_charger_cycle,
   input wire logic cycle_start,
   input wire logic [NPROF-1:0] profile_enable,
   input wire logic custom_timeout_en,
   input wire logic over_charging_threshold,
   input wire logic removal_event,
   // notification pin, open drain
   output logic alert_o,
   output logic alert_oe,
   // port power
   output logic port_switch_open,
   output logic bus_discharge_on,
   // charge rationing
   output logic [`UCC_CHARGE_W-1:0] accumulated_charge,
   output logic quota_reached,
   output logic quota_report,
   output logic quota_disconnect,
   output logic quota_sleep_req,
   // serial bus and emulation
   output logic bus_timeout_enable,
   output ucc_pkg::ucc_emu_out_type emu_status
);
   import ucc_pkg::*;

   typedef struct packed {
      ucc_gen_cfg_type gen;
      ucc_emu_cfg_type emu;
      logic [`UCC_CHARGE_W-1:0] charge;
      logic flag;
      logic alert;
      logic sw_open;
      logic dis_on;
      logic rep;
      logic disc;
      logic sleep;
      logic to_en;
      logic [7:0] rdata;
   } ucc_top_state_type;

   ucc_top_state_type s, n;
   logic wr_gen, wr_emu, clr, reached;
   ucc_gen_cfg_type general_config;
   ucc_emu_cfg_type emulation_config;

   // register select, shared by the read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : hit

   // saturate so a long session cannot wrap back under the threshold
   function automatic logic [`UCC_CHARGE_W-1:0] sat_add(
      input logic [`UCC_CHARGE_W-1:0] a,
      input logic [`UCC_CHARGE_W-1:0] b
   );
      logic [`UCC_CHARGE_W:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[`UCC_CHARGE_W] ? '1 : t[`UCC_CHARGE_W-1:0];
   endfunction : sat_add

   assign general_config = s.gen;
   assign emulation_config = s.emu;

   always_comb
   begin
      n = s;
      wr_gen = reg_req.wr && hit(reg_req.addr, `UCC_OFS_GEN);
      wr_emu = reg_req.wr && hit(reg_req.addr, `UCC_OFS_EMU);
      // clear acts on the write, never stored
      clr = wr_gen && reg_req.wdata[`UCC_BIT_CLEAR];
      reached = s.gen.quota_enable && s.charge >= quota_threshold;

      if (wr_gen)
         n.gen = ucc_gen_cfg_type'(reg_req.wdata & `UCC_KEEP_GEN);
      if (wr_emu)
         n.emu = ucc_emu_cfg_type'(reg_req.wdata & `UCC_KEEP_EMU);
      // no power state touches the registers

      // disabled holds the total at zero
      if (!s.gen.quota_enable || clr)
         n.charge = '0;
      else if (current_sample.valid)
         n.charge = sat_add(s.charge, current_sample.value);

      if (!s.gen.quota_enable || clr)
         n.flag = 1'b0;
      else if (reached && s.gen.quota_action_select != QA_IGNORE)
         n.flag = 1'b1;

      n.rep = n.flag && (n.gen.quota_action_select == QA_REPORT ||
                         n.gen.quota_action_select == QA_REPORT_DISC);
      n.disc = n.flag && (n.gen.quota_action_select == QA_REPORT_DISC ||
                          n.gen.quota_action_select == QA_DISC_SLEEP);
      n.sleep = n.flag && n.gen.quota_action_select == QA_DISC_SLEEP;

      n.alert = !s.gen.alert_mask &&
                (events.error_pending || events.indicator_pending ||
                 (s.flag && s.rep) ||
                 (s.gen.alert_link &&
                  (events.low_current_flag || events.thermal_regulation_flag)));

      n.sw_open = s.gen.forced_bus_discharge && power_state == PS_ACTIVE;
      n.dis_on = n.sw_open;

      // the timeout enable follows the bit, inverted
      n.to_en = !n.emu.bus_timeout_off;

      // read data lands one cycle after the read strobe
      if (reg_req.rd)
      begin
         if (hit(reg_req.addr, `UCC_OFS_GEN))
            n.rdata = s.gen & `UCC_KEEP_GEN;
         else if (hit(reg_req.addr, `UCC_OFS_EMU))
            n.rdata = s.emu & `UCC_KEEP_EMU;
         else
            n.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
      begin
         s <= '0;
         s.gen <= ucc_gen_cfg_type'(`UCC_RST_GEN);
         s.emu <= ucc_emu_cfg_type'(`UCC_RST_EMU);
         s.to_en <= 1'b0;
      end
      else
         s <= n;

   assign reg_rdata = s.rdata;
   assign alert_o = 1'b0;
   assign alert_oe = s.alert;
   assign port_switch_open = s.sw_open;
   assign bus_discharge_on = s.dis_on;
   assign accumulated_charge = s.charge;
   assign quota_reached = s.flag;
   assign quota_report = s.rep;
   assign quota_disconnect = s.disc;
   assign quota_sleep_req = s.sleep;
   assign bus_timeout_enable = s.to_en;

   ucc_emu_cycle #(
      .NPROF(NPROF),
      .CYC_PER_MS(CYC_PER_MS),
      .DWELL_MS(DWELL_MS),
      .DISCH_MS(DISCH_MS)
   ) u_emu (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .cfg(s.emu),
      .dedicated_charger_cycle(dedicated_charger_cycle),
      .cycle_start(cycle_start),
      .profile_enable(profile_enable),
      .custom_timeout_en(custom_timeout_en),
      .over_charging_threshold(over_charging_threshold),
      .removal_event(removal_event),
      .status(emu_status)
   );

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_mask_quiet;
      general_config.alert_mask |=> !alert_oe;
   endproperty
   a_mask_quiet: assert property (p_mask_quiet) else $error("alert while masked");

   property p_error_alert;
      !general_config.alert_mask && events.error_pending |=> alert_oe;
   endproperty
   a_error_alert: assert property (p_error_alert) else $error("error not alerted");

   property p_link;
      !general_config.alert_mask && general_config.alert_link &&
      (events.low_current_flag || events.thermal_regulation_flag) |=> alert_oe;
   endproperty
   a_link: assert property (p_link) else $error("linked flag not alerted");

   property p_discharge;
      general_config.forced_bus_discharge && power_state == PS_ACTIVE
      |=> port_switch_open && bus_discharge_on;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge not forced");

   property p_accum;
      general_config.quota_enable && current_sample.valid && !clr &&
      current_sample.value != '0 && !accumulated_charge[`UCC_CHARGE_W-1] &&
      !current_sample.value[`UCC_CHARGE_W-1]
      |=> accumulated_charge > $past(accumulated_charge);
   endproperty
   a_accum: assert property (p_accum) else $error("charge not accumulated");

   property p_off_zero;
      !general_config.quota_enable |=> accumulated_charge == '0 && !quota_reached;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("charge kept while off");

   property p_clear;
      clr |=> accumulated_charge == '0 && !quota_reached && !quota_disconnect;
   endproperty
   a_clear: assert property (p_clear) else $error("quota clear ignored");

   sequence s_cleared_quiet;
      clr && !events.error_pending && !events.indicator_pending &&
      !events.low_current_flag && !events.thermal_regulation_flag;
   endsequence
   property p_release;
      s_cleared_quiet ##1 (!events.error_pending && !events.indicator_pending &&
      !events.low_current_flag && !events.thermal_regulation_flag) |=> !alert_oe;
   endproperty
   a_release: assert property (p_release) else $error("alert held after clear");

   property p_sleep_act;
      quota_reached && general_config.quota_action_select == QA_DISC_SLEEP
      |-> quota_sleep_req && quota_disconnect && !quota_report;
   endproperty
   a_sleep_act: assert property (p_sleep_act) else $error("bad quota action");

   property p_ignore;
      general_config.quota_action_select == QA_IGNORE && !quota_reached && !wr_gen
      |=> !quota_reached;
   endproperty
   a_ignore: assert property (p_ignore) else $error("flag set in ignore");

   property p_retain;
      power_state == PS_SLEEP && !reg_req.wr
      |=> general_config == $past(general_config) && emulation_config == $past(emulation_config);
   endproperty
   a_retain: assert property (p_retain) else $error("config lost in sleep");

   property p_bus_to;
      emulation_config.bus_timeout_off |-> !bus_timeout_enable;
   endproperty
   a_bus_to: assert property (p_bus_to) else $error("timeout left enabled");

   property p_no_to;
      dedicated_charger_cycle && emulation_config.profile_timeout_off &&
      emu_status.apply && !emu_status.accepted && over_charging_threshold
      ##1 dedicated_charger_cycle |-> emu_status.accepted;
   endproperty
   a_no_to: assert property (p_no_to) else $error("profile not accepted");

   property p_done;
      emu_status.lines_hiz |-> emu_status.switch_closed && emu_status.custom_limit_mode &&
      !emu_status.apply;
   endproperty
   a_done: assert property (p_done) else $error("cycle end outputs wrong");

   property p_unimpl;
      reg_req.rd |=> reg_rdata[6] == 1'b0 && (reg_rdata[5] == 1'b0 ||
      $past(reg_req.addr) != `UCC_OFS_EMU);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit reads one");

   property p_drop;
      !general_config.quota_enable |=> !quota_report && !quota_disconnect && !quota_sleep_req;
   endproperty
   a_drop: assert property (p_drop) else $error("response kept while off");

   property p_report;
      quota_reached && general_config.quota_action_select == QA_REPORT
      |-> quota_report && !quota_disconnect && !quota_sleep_req;
   endproperty
   a_report: assert property (p_report) else $error("report action wrong");

   property p_report_disc;
      quota_reached && general_config.quota_action_select == QA_REPORT_DISC
      |-> quota_report && quota_disconnect && !quota_sleep_req;
   endproperty
   a_report_disc: assert property (p_report_disc) else $error("disconnect action wrong");

   property p_gen_write;
      wr_gen |=> general_config == ($past(reg_req.wdata) & `UCC_KEEP_GEN);
   endproperty
   a_gen_write: assert property (p_gen_write) else $error("general write wrong");

   property p_emu_write;
      wr_emu |=> emulation_config == ($past(reg_req.wdata) & `UCC_KEEP_EMU);
   endproperty
   a_emu_write: assert property (p_emu_write) else $error("emulation write wrong");

   property p_to_on;
      !emulation_config.bus_timeout_off |-> bus_timeout_enable;
   endproperty
   a_to_on: assert property (p_to_on) else $error("timeout left disabled");

   property p_sw_closed;
      !(general_config.forced_bus_discharge && power_state == PS_ACTIVE) |=> !port_switch_open;
   endproperty
   a_sw_closed: assert property (p_sw_closed) else $error("switch open unforced");

   property p_no_exit;
      dedicated_charger_cycle && emulation_config.profile_timeout_off && emu_status.apply &&
      !emu_status.accepted && !over_charging_threshold |=> emu_status.apply;
   endproperty
   a_no_exit: assert property (p_no_exit) else $error("profile left on timeout");
endmodule : ucc_config_regs

/* sim/ucc_device_model.sv */
// portable device on the port: draws charge in regular measured steps
`timescale 1ns/1ns
module ucc_device_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // control from the bench
   input wire logic draw_en,
   // measurement seen by the controller
   output ucc_pkg::ucc_sample_type current_sample,
   output logic over_charging_threshold
);
   import ucc_pkg::*;
   logic [1:0] phase;
   // one sample every fourth cycle, like a slow monitor conversion
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         phase <= 2'h0;
         current_sample <= '0;
         over_charging_threshold <= 1'b0;
      end
      else
      begin
         phase <= phase + 2'h1;
         current_sample.valid <= draw_en && (phase == 2'h3);
         current_sample.value <= draw_en ? 16'h0004 : ~current_sample.value;
         over_charging_threshold <= draw_en;
      end
   end
endmodule : ucc_device_model

/* sim/test_ucc_config_regs.sv */
// self-checking bench for the charger port configuration registers
`timescale 1ns/1ns
module test_ucc_config_regs;
   import ucc_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   ucc_reg_req_type reg_req = '0;
   ucc_event_type events = '0;
   ucc_pwr_type power_state = PS_ACTIVE;
   ucc_sample_type current_sample;
   logic [15:0] quota_threshold = 16'h0010;
   logic dedicated_charger_cycle = 1'b0;
   logic cycle_start = 1'b0;
   logic [9:0] profile_enable = 10'h001;
   logic custom_timeout_en = 1'b0;
   logic removal_event = 1'b0;
   logic draw_en = 1'b0;
   logic over_charging_threshold, alert_o, alert_oe, port_switch_open, bus_discharge_on;
   logic quota_reached, quota_report, quota_disconnect, quota_sleep_req, bus_timeout_enable;
   logic [7:0] reg_rdata;
   logic [15:0] accumulated_charge;
   ucc_emu_out_type emu_status;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   int i;
   int a;
   logic [7:0] ag [5] = '{8'h00, 8'h80, 8'h20, 8'h00, 8'ha0};
   logic [3:0] ae [5] = '{4'h8, 4'h8, 4'h2, 4'h2, 4'h1};
   logic ax [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

   always #4 clk_sys = ~clk_sys;

   ucc_device_model dev_u (.clk_sys(clk_sys), .resetn(resetn), .draw_en(draw_en),
      .current_sample(current_sample), .over_charging_threshold(over_charging_threshold));

   // short millisecond so dwell and reset waits stay a few hundred cycles
   ucc_config_regs #(.NPROF(10), .CYC_PER_MS(4), .DWELL_MS(2), .DISCH_MS(1)) dut_u (
      .clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .events(events), .power_state(power_state), .current_sample(current_sample),
      .quota_threshold(quota_threshold), .dedicated_charger_cycle(dedicated_charger_cycle),
      .cycle_start(cycle_start), .profile_enable(profile_enable),
      .custom_timeout_en(custom_timeout_en), .over_charging_threshold(over_charging_threshold),
      .removal_event(removal_event), .alert_o(alert_o), .alert_oe(alert_oe),
      .port_switch_open(port_switch_open), .bus_discharge_on(bus_discharge_on),
      .accumulated_charge(accumulated_charge), .quota_reached(quota_reached),
      .quota_report(quota_report), .quota_disconnect(quota_disconnect),
      .quota_sleep_req(quota_sleep_req), .bus_timeout_enable(bus_timeout_enable),
      .emu_status(emu_status));

   task close_out;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task chk_v(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_v

   task chk_b(input string what, input logic exp, input logic got);
      chk_v(what, {15'h0000, exp}, {15'h0000, got});
   endtask : chk_b

   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask : wr

   task rd_chk(input string what, input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      chk_v(what, {8'h00, exp}, {8'h00, reg_rdata});
   endtask : rd_chk

   task start_cycle;
      @(posedge clk_sys);
      cycle_start <= 1'b1;
      @(posedge clk_sys);
      cycle_start <= 1'b0;
      #1;
   endtask : start_cycle

   task set_draw(input logic on);
      @(posedge clk_sys);
      draw_en <= on;
   endtask : set_draw

   // a hang ends in the same report as a normal run
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         err_total++;
         close_out();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      rd_chk("gen reset", 8'h15, 8'h01);
      rd_chk("emu reset", 8'h16, 8'h8c);
      rd_chk("unmapped", 8'h20, 8'h00);
      chk_b("timeout en", 1'b0, bus_timeout_enable);
      wr(8'h15, 8'hff);
      wr(8'h16, 8'hff);
      wr(8'h20, 8'h00);
      rd_chk("gen ones", 8'h15, 8'hbb);
      rd_chk("emu ones", 8'h16, 8'h9f);
      wr(8'h16, 8'h0c);
      cyc(2);
      chk_b("timeout en", 1'b1, bus_timeout_enable);
      for (i = 0; i < 5; i++)
      begin
         wr(8'h15, ag[i]);
         @(posedge clk_sys);
         events <= ae[i];
         cyc(2);
         chk_b("alert", ax[i], alert_oe);
      end
      chk_b("alert data", 1'b0, alert_o);
      @(posedge clk_sys);
      events <= '0;
      wr(8'h15, 8'h10);
      cyc(2);
      chk_b("switch open", 1'b1, port_switch_open);
      chk_b("discharge", 1'b1, bus_discharge_on);
      @(posedge clk_sys);
      power_state <= PS_SLEEP;
      cyc(20);
      @(posedge clk_sys);
      power_state <= PS_ACTIVE;
      rd_chk("gen sleep", 8'h15, 8'h10);
      rd_chk("emu sleep", 8'h16, 8'h0c);
      wr(8'h15, 8'h00);
      cyc(2);
      chk_b("switch open", 1'b0, port_switch_open);
      for (a = 0; a < 4; a++)
      begin
         wr(8'h15, {6'h02, 2'(a)});
         set_draw(1'b1);
         for (i = 0; i < 100 && quota_reached !== 1'b1; i++) cyc(1);
         set_draw(1'b0);
         cyc(2);
         chk_b("reached", a != 3, quota_reached);
         chk_b("report", a < 2, quota_report);
         chk_b("disconnect", a == 1 || a == 2, quota_disconnect);
         chk_b("sleep req", a == 2, quota_sleep_req);
         chk_b("alert", a < 2, alert_oe);
         chk_b("charge ok", 1'b1, accumulated_charge >= quota_threshold);
         wr(8'h15, {6'h03, 2'(a)});
         cyc(2);
         chk_v("charge", 16'h0000, accumulated_charge);
         chk_b("reached", 1'b0, quota_reached);
         chk_b("alert", 1'b0, alert_oe);
      end
      wr(8'h15, 8'h08);
      set_draw(1'b1);
      for (i = 0; i < 100 && quota_reached !== 1'b1; i++) cyc(1);
      chk_b("reached", 1'b1, quota_reached);
      wr(8'h15, 8'h00);
      cyc(12);
      chk_b("reached", 1'b0, quota_reached);
      chk_b("report", 1'b0, quota_report);
      chk_v("charge", 16'h0000, accumulated_charge);
      set_draw(1'b0);
      wr(8'h16, 8'h00);
      @(posedge clk_sys);
      dedicated_charger_cycle <= 1'b1;
      start_cycle();
      chk_b("apply", 1'b1, emu_status.apply);
      cyc(5);
      chk_b("apply dwell", 1'b1, emu_status.apply);
      for (i = 0; i < 30 && emu_status.lines_hiz !== 1'b1; i++) cyc(1);
      // 2 ms of 4 cycles: the profile ends 8 cycles after apply, 5 waited
      chk_v("dwell", 16'h0003, 16'(i));
      cyc(20);
      chk_b("hiz", 1'b1, emu_status.lines_hiz);
      chk_b("closed", 1'b1, emu_status.switch_closed);
      chk_b("custom", 1'b1, emu_status.custom_limit_mode);
      chk_b("no reset", 1'b0, emu_status.reset_active);
      @(posedge clk_sys);
      dedicated_charger_cycle <= 1'b0;
      wr(8'h16, 8'h08);
      @(posedge clk_sys);
      dedicated_charger_cycle <= 1'b1;
      start_cycle();
      for (i = 0; i < 30 && emu_status.reset_active !== 1'b1; i++) cyc(1);
      cyc(150);
      chk_b("reset wait", 1'b1, emu_status.reset_active);
      for (i = 0; i < 100 && emu_status.apply !== 1'b1; i++) cyc(1);
      // 50 ms plus 1 ms discharge is 204 cycles, 150 waited above
      chk_v("reset len", 16'h0036, 16'(i));
      chk_b("restart", 1'b1, emu_status.apply);
      chk_v("profile", 16'h0000, {12'h000, emu_status.profile_index});
      @(posedge clk_sys);
      dedicated_charger_cycle <= 1'b0;
      cyc(2);
      chk_b("idle", 1'b0, emu_status.apply | emu_status.reset_active);
      wr(8'h16, 8'h10);
      @(posedge clk_sys);
      profile_enable <= 10'h200;
      custom_timeout_en <= 1'b1;
      dedicated_charger_cycle <= 1'b1;
      start_cycle();
      cyc(40);
      chk_b("no timeout", 1'b1, emu_status.apply);
      chk_v("profile", 16'h0009, {12'h000, emu_status.profile_index});
      set_draw(1'b1);
      for (i = 0; i < 10 && emu_status.accepted !== 1'b1; i++) cyc(1);
      chk_b("accepted", 1'b1, emu_status.accepted);
      @(posedge clk_sys);
      removal_event <= 1'b1;
      draw_en <= 1'b0;
      @(posedge clk_sys);
      removal_event <= 1'b0;
      cyc(2);
      chk_b("released", 1'b0, emu_status.accepted);
      close_out();
   end
endmodule : test_ucc_config_regs
